/* logic/led_regs_pkg.sv */
// Register map, field layout and timing constants of the LED
// fault and delay register bank. Shared by every design file but bit_sync.
package led_regs_pkg;

  // Serial bus identity and register indexes
  localparam logic [6:0] DEVICE_ADDRESS       = 7'h28;
  localparam logic [7:0] FAULT_REPORT_IDX     = 8'h05;
  localparam logic [7:0] TRANSITION_DELAY_IDX = 8'h06;
  localparam logic [7:0] FAULT_STATUS_IDX     = 8'h07;

  // Reset values, and the value read from an unmapped index
  localparam logic       FAULT_REPORT_RESET = 1'b1;
  localparam logic [7:0] DELAY_RESET        = 8'hFF;
  localparam logic [7:0] FAULT_STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // Delay register fields
  localparam int RED_DELAY_LSB   = 6;
  localparam int BLUE_DELAY_LSB  = 3;
  localparam int GREEN_DELAY_LSB = 0;
  localparam logic [7:0] DELAY_RESERVED_ONES = 8'h24;

  // Fault status fields
  localparam int GREEN_OPEN_BIT  = 7;
  localparam int GREEN_SHORT_BIT = 6;
  localparam int BLUE_OPEN_BIT   = 4;
  localparam int BLUE_SHORT_BIT  = 3;
  localparam int RED_OPEN_BIT    = 1;
  localparam int RED_SHORT_BIT   = 0;

  // Colour channel numbering on the pin vectors
  localparam int COLOUR_RED   = 0;
  localparam int COLOUR_GREEN = 1;
  localparam int COLOUR_BLUE  = 2;

  // Settling delay timing
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int DELAY_MIN_NS    = 5000;
  localparam int DELAY_STEP_NS   = 10000;
  localparam int DELAY_MAX_NS    = 35000;
  localparam int DELAY_BASE_CYCLES =
    (DELAY_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DELAY_STEP_CYCLES =
    (DELAY_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DELAY_MAX_CYCLES =
    (DELAY_MAX_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage

/* logic/bit_sync.sv */
// Two flip-flop synchroniser for levels and toggles.
// Assumes each bit is a level or toggle; words are not safe here.
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // Data
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

/* logic/colour_delay_timer.sv */
// Settling timer between colour phases.
// Assumes i_start is a one-cycle pulse on the core clock.
`timescale 1ns/10ps
module colour_delay_timer #(
  parameter int COUNT_WIDTH = 10
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_start,
  input  wire logic [1:0] i_code,
  output logic            o_done
);

  localparam logic [COUNT_WIDTH-1:0] BASE =
    COUNT_WIDTH'(led_regs_pkg::DELAY_BASE_CYCLES);
  localparam logic [COUNT_WIDTH-1:0] STEP =
    COUNT_WIDTH'(led_regs_pkg::DELAY_STEP_CYCLES);

  logic [COUNT_WIDTH-1:0] count_reg;
  logic                   busy_reg;

  if (led_regs_pkg::DELAY_MAX_CYCLES >= (1 << COUNT_WIDTH)) begin
    $error("COUNT_WIDTH too small for the longest delay");
  end

  // Code 0..3 gives 5, 15, 25, 35 us; load is one less than the span
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
      o_done    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        count_reg <= BASE + STEP * COUNT_WIDTH'(i_code)
                     - COUNT_WIDTH'(1);
        busy_reg  <= 1'b1;
      end else if (busy_reg) begin
        if (count_reg == '0) begin
          busy_reg <= 1'b0;
          o_done   <= 1'b1;
        end else begin
          count_reg <= count_reg - COUNT_WIDTH'(1);
        end
      end
    end
  end

endmodule

/* logic/led_fault_and_delay_regs.sv */
// Fault-report, transition-delay and fault-status registers of a
// sequential three-colour LED driver, reached over a two-wire serial
// bus sampled on its own fast link clock.
// Assumes the link clock is much faster than the serial clock, and
// that fault and colour request pins are asynchronous levels.
`timescale 1ns/10ps

// Overview of operation
// - Enable bit gates fault indicator; resets one
// - Enable register bits 7:1 read zero
// - Wait settling interval before next colour on
// - Delay 5 to 35 us, 10 us steps
// - Delay register resets to all ones
// - Red 7:6, blue 4:3, green 1:0
// - Delay bits 5 and 2 read one
// - Any fault while enabled raises indicator
// - Fault status read only, resets zero
// - Disable then enable clears latched faults
// - Bit 7 green open, 6 green short
// - Bit 4 blue open, 3 blue short
// - Bit 1 red open, 0 red short
// - Write takes effect at final acknowledge
module led_fault_and_delay_regs (
  // Core clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // Serial link
  input  wire logic       i_link_clock,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  // LED fault detectors, index 0 red, 1 green, 2 blue
  input  wire logic [2:0] i_led_open,
  input  wire logic [2:0] i_led_short,
  // Colour sequencing
  input  wire logic [2:0] i_colour_request,
  output logic      [2:0] o_led_on,
  // Fault indicator
  output logic            o_fault
);

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_INDEX     = 4'h2,
    ST_INDEX_ACK = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RDATA_ACK = 4'hC
  } link_state_e;

  typedef enum logic [1:0] {
    SEQ_DARK   = 2'b00,
    SEQ_SETTLE = 2'b01,
    SEQ_LIT    = 2'b11
  } seq_state_e;

  // ---------------- Link domain ----------------
  logic        rst_link_n;
  logic        scl_s, sda_s, scl_q, sda_q;
  logic        start_det, stop_det, scl_rise, scl_fall;
  link_state_e lstate_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  index_reg;
  logic [7:0]  wr_data_reg;
  logic        wr_toggle_reg;
  logic        rd_toggle_reg;
  logic        rd_ack_s, rd_ack_q;
  logic [7:0]  rd_shift_reg;
  logic        master_ack_reg;

  // Release of reset is aligned to the link clock
  bit_sync #(.WIDTH(1)) u_link_rst (
    .i_clock (i_link_clock),
    .i_rst_n (i_rst_n),
    .i_async (1'b1),
    .o_sync  (rst_link_n)
  );

  bit_sync #(.WIDTH(2)) u_pin_sync (
    .i_clock (i_link_clock),
    .i_rst_n (rst_link_n),
    .i_async ({i_scl, i_sda}),
    .o_sync  ({scl_s, sda_s})
  );

  always_ff @(posedge i_link_clock or negedge rst_link_n) begin
    if (!rst_link_n) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;

  // Read data handed back from the core domain
  logic [7:0] rd_data_core_reg;
  logic       rd_ack_toggle_reg;

  bit_sync #(.WIDTH(1)) u_rd_ack_sync (
    .i_clock (i_link_clock),
    .i_rst_n (rst_link_n),
    .i_async (rd_ack_toggle_reg),
    .o_sync  (rd_ack_s)
  );

  always_ff @(posedge i_link_clock or negedge rst_link_n) begin
    if (!rst_link_n) begin
      rd_ack_q     <= 1'b0;
      rd_shift_reg <= 8'h00;
    end else begin
      rd_ack_q <= rd_ack_s;
      // Core word is held stable until the next request
      if (rd_ack_s != rd_ack_q)
        rd_shift_reg <= rd_data_core_reg;
      else if (lstate_reg == ST_RDATA && scl_fall && bit_cnt_reg != 4'h8)
        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
    end
  end

  // Serial slave: address, index, data bytes with acknowledges
  always_ff @(posedge i_link_clock or negedge rst_link_n) begin
    if (!rst_link_n) begin
      lstate_reg     <= ST_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      index_reg      <= 8'h00;
      wr_data_reg    <= 8'h00;
      wr_toggle_reg  <= 1'b0;
      rd_toggle_reg  <= 1'b0;
      master_ack_reg <= 1'b0;
      o_sda_out      <= 1'b0;
      o_sda_oe       <= 1'b0;
    end else if (start_det) begin
      lstate_reg  <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      o_sda_oe    <= 1'b0;
    end else if (stop_det) begin
      lstate_reg <= ST_IDLE;
      o_sda_oe   <= 1'b0;
    end else begin
      case (lstate_reg)
        ST_ADDR, ST_INDEX, ST_WDATA: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            o_sda_oe    <= 1'b1;
            case (lstate_reg)
              ST_ADDR: begin
                if (shift_reg[7:1] == led_regs_pkg::DEVICE_ADDRESS) begin
                  lstate_reg     <= ST_ADDR_ACK;
                  master_ack_reg <= shift_reg[0];
                end else begin
                  lstate_reg <= ST_IDLE;
                  o_sda_oe   <= 1'b0;
                end
              end
              ST_INDEX: begin
                index_reg  <= shift_reg;
                lstate_reg <= ST_INDEX_ACK;
              end
              default: begin
                wr_data_reg <= shift_reg;
                lstate_reg  <= ST_WDATA_ACK;
              end
            endcase
          end
        end
        ST_ADDR_ACK: begin
          // Read fetches the index left by a prior write
          if (scl_rise && master_ack_reg)
            rd_toggle_reg <= ~rd_toggle_reg;
          if (scl_fall) begin
            lstate_reg <= master_ack_reg ? ST_RDATA : ST_INDEX;
            o_sda_oe   <= master_ack_reg & ~rd_shift_reg[7];
          end
        end
        ST_INDEX_ACK: begin
          if (scl_fall) begin
            lstate_reg <= ST_WDATA;
            o_sda_oe   <= 1'b0;
          end
        end
        ST_WDATA_ACK: begin
          // Commit on the serial clock rise inside the last ack
          if (scl_rise)
            wr_toggle_reg <= ~wr_toggle_reg;
          if (scl_fall) begin
            lstate_reg <= ST_WDATA;
            index_reg  <= index_reg + 8'h01;
            o_sda_oe   <= 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_rise)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            lstate_reg  <= ST_RDATA_ACK;
            o_sda_oe    <= 1'b0;
          end else if (scl_fall)
            o_sda_oe <= ~rd_shift_reg[6];
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            master_ack_reg <= ~sda_s;
            if (!sda_s) begin
              index_reg     <= index_reg + 8'h01;
              rd_toggle_reg <= ~rd_toggle_reg;
            end
          end
          if (scl_fall) begin
            lstate_reg <= master_ack_reg ? ST_RDATA : ST_IDLE;
            o_sda_oe   <= master_ack_reg & ~rd_shift_reg[7];
          end
        end
        default: begin
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- Core domain ----------------
  logic       wr_tog_s, wr_tog_q, rd_tog_s, rd_tog_q;
  logic       wr_event, rd_event;
  logic [2:0] open_s, short_s, request_s;
  logic       report_en_reg;
  logic [5:0] delay_codes_reg;
  logic [7:0] fault_status_reg;
  logic [7:0] delay_view, fault_detect, fault_status_next;
  logic       clear_faults;

  bit_sync #(.WIDTH(2)) u_tog_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({wr_toggle_reg, rd_toggle_reg}),
    .o_sync  ({wr_tog_s, rd_tog_s})
  );

  bit_sync #(.WIDTH(9)) u_led_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_led_open, i_led_short, i_colour_request}),
    .o_sync  ({open_s, short_s, request_s})
  );

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_tog_q <= 1'b0;
      rd_tog_q <= 1'b0;
    end else begin
      wr_tog_q <= wr_tog_s;
      rd_tog_q <= rd_tog_s;
    end
  end

  // Index and data words are stable while the toggle crosses
  assign wr_event = wr_tog_s != wr_tog_q;
  assign rd_event = rd_tog_s != rd_tog_q;

  assign delay_view = {delay_codes_reg[5:4], 1'b0,
                       delay_codes_reg[3:2], 1'b0,
                       delay_codes_reg[1:0]}
                      | led_regs_pkg::DELAY_RESERVED_ONES;

  // Fault status is not writable from the bus
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      report_en_reg   <= led_regs_pkg::FAULT_REPORT_RESET;
      delay_codes_reg <= {led_regs_pkg::DELAY_RESET[7:6],
                          led_regs_pkg::DELAY_RESET[4:3],
                          led_regs_pkg::DELAY_RESET[1:0]};
    end else if (wr_event) begin
      if (index_reg == led_regs_pkg::FAULT_REPORT_IDX)
        report_en_reg <= wr_data_reg[0];
      if (index_reg == led_regs_pkg::TRANSITION_DELAY_IDX)
        delay_codes_reg <= {
          wr_data_reg[led_regs_pkg::RED_DELAY_LSB +: 2],
          wr_data_reg[led_regs_pkg::BLUE_DELAY_LSB +: 2],
          wr_data_reg[led_regs_pkg::GREEN_DELAY_LSB +: 2]};
    end
  end

  assign clear_faults = wr_event && !report_en_reg && wr_data_reg[0]
                        && index_reg == led_regs_pkg::FAULT_REPORT_IDX;

  // Each detector lands in its own sticky bit
  always_comb begin
    fault_detect = 8'h00;
    fault_detect[led_regs_pkg::GREEN_OPEN_BIT] =
      open_s[led_regs_pkg::COLOUR_GREEN];
    fault_detect[led_regs_pkg::GREEN_SHORT_BIT] =
      short_s[led_regs_pkg::COLOUR_GREEN];
    fault_detect[led_regs_pkg::BLUE_OPEN_BIT] =
      open_s[led_regs_pkg::COLOUR_BLUE];
    fault_detect[led_regs_pkg::BLUE_SHORT_BIT] =
      short_s[led_regs_pkg::COLOUR_BLUE];
    fault_detect[led_regs_pkg::RED_OPEN_BIT] =
      open_s[led_regs_pkg::COLOUR_RED];
    fault_detect[led_regs_pkg::RED_SHORT_BIT] =
      short_s[led_regs_pkg::COLOUR_RED];
    // A detection in the clearing cycle is dropped, as reporting is still off then
    fault_status_next = (clear_faults ? 8'h00 : fault_status_reg)
                        | (report_en_reg ? fault_detect : 8'h00);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_status_reg <= led_regs_pkg::FAULT_STATUS_RESET;
      o_fault          <= 1'b0;
    end else begin
      fault_status_reg <= fault_status_next;
      o_fault          <= report_en_reg & (|fault_status_next);
    end
  end

  // Read answer back to the link domain
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data_core_reg  <= 8'h00;
      rd_ack_toggle_reg <= 1'b0;
    end else if (rd_event) begin
      rd_ack_toggle_reg <= ~rd_ack_toggle_reg;
      case (index_reg)
        led_regs_pkg::FAULT_REPORT_IDX:
          rd_data_core_reg <= {7'h00, report_en_reg};
        led_regs_pkg::TRANSITION_DELAY_IDX:
          rd_data_core_reg <= delay_view;
        led_regs_pkg::FAULT_STATUS_IDX:
          rd_data_core_reg <= fault_status_reg;
        default:
          rd_data_core_reg <= led_regs_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // Colour sequencer: dark, settle on the new colour's delay, lit
  seq_state_e seq_reg;
  logic [2:0] target_reg;
  logic [2:0] target_next;
  logic [1:0] code_sel;
  logic       timer_start, timer_done;

  always_comb begin
    target_next = 3'b000;
    if (request_s[led_regs_pkg::COLOUR_RED])
      target_next[led_regs_pkg::COLOUR_RED] = 1'b1;
    else if (request_s[led_regs_pkg::COLOUR_GREEN])
      target_next[led_regs_pkg::COLOUR_GREEN] = 1'b1;
    else if (request_s[led_regs_pkg::COLOUR_BLUE])
      target_next[led_regs_pkg::COLOUR_BLUE] = 1'b1;
    if (target_next[led_regs_pkg::COLOUR_RED])
      code_sel = delay_codes_reg[5:4];
    else if (target_next[led_regs_pkg::COLOUR_BLUE])
      code_sel = delay_codes_reg[3:2];
    else
      code_sel = delay_codes_reg[1:0];
  end

  assign timer_start = (target_next != target_reg) && (target_next != 3'b000);

  colour_delay_timer #(.COUNT_WIDTH(10)) u_timer (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_start (timer_start),
    .i_code  (code_sel),
    .o_done  (timer_done)
  );

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_reg    <= SEQ_DARK;
      target_reg <= 3'b000;
      o_led_on   <= 3'b000;
    end else begin
      target_reg <= target_next;
      case (seq_reg)
        SEQ_DARK, SEQ_LIT, SEQ_SETTLE: begin
          if (target_next != target_reg) begin
            o_led_on <= 3'b000;
            seq_reg  <= timer_start ? SEQ_SETTLE : SEQ_DARK;
          end else if (seq_reg == SEQ_SETTLE && timer_done) begin
            o_led_on <= target_reg;
            seq_reg  <= SEQ_LIT;
          end
        end
        default: begin
          seq_reg  <= SEQ_DARK;
          o_led_on <= 3'b000;
        end
      endcase
    end
  end

endmodule

/* bench/led_fault_and_delay_regs_asserts.sv */
// Port-level checks of the LED fault and delay register bank.
// Assumes the serial host moves SCL only on core clock edges.
`timescale 1ns/10ps
module led_fault_and_delay_regs_asserts (
  // Clocks and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_link_clock,
  // Serial link
  input  wire logic       i_scl,
  input  wire logic       o_sda_out,
  input  wire logic       o_sda_oe,
  // LED side
  input  wire logic [2:0] i_led_open,
  input  wire logic [2:0] i_led_short,
  input  wire logic [2:0] i_colour_request,
  input  wire logic [2:0] o_led_on,
  input  wire logic       o_fault
);
  logic [5:0]  fault_hist;
  logic [6:0]  scl_quiet;
  logic        scl_prev;
  logic [10:0] dark_cnt;
  logic [2:0]  req_prev;

  // Detector history spans the pin synchroniser and status latch
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_hist <= 6'h00;
    end else begin
      fault_hist <= {fault_hist[4:0], |(i_led_open | i_led_short)};
    end
  end

  // Register writes land only shortly after an SCL edge
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_prev  <= 1'b1;
      scl_quiet <= 7'h00;
    end else begin
      scl_prev <= i_scl;
      if (i_scl != scl_prev) begin
        scl_quiet <= 7'h00;
      end else if (scl_quiet != 7'h7F) begin
        scl_quiet <= scl_quiet + 7'h01;
      end
    end
  end

  // Dark time since the last request change, saturating
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_prev <= 3'h0;
      dark_cnt <= 11'h000;
    end else begin
      req_prev <= i_colour_request;
      if (o_led_on != 3'h0 || i_colour_request != req_prev) begin
        dark_cnt <= 11'h000;
      end else if (dark_cnt != 11'h7FF) begin
        dark_cnt <= dark_cnt + 11'h001;
      end
    end
  end

  a_fault_cause:
    assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $rose(o_fault) |-> fault_hist != 6'h00)
    else $error("Fault indicator rose without a fault input");
  a_fault_sticky:
    assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $fell(o_fault) |-> scl_quiet < 7'h10)
    else $error("Fault indicator fell without a register write");
  a_led_onehot:
    assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $onehot0(o_led_on))
    else $error("More than one colour lit");
  a_no_swap:
    assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ($past(o_led_on) != 3'h0 && o_led_on != 3'h0)
      |-> o_led_on == $past(o_led_on))
    else $error("Colour changed without a dark interval");
  a_settle_min:
    assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ($past(o_led_on) == 3'h0 && o_led_on != 3'h0)
      |-> dark_cnt >= 11'(led_regs_pkg::DELAY_BASE_CYCLES))
    else $error("Colour lit before the shortest settling delay");
  a_settle_max:
    assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ($past(o_led_on) == 3'h0 && o_led_on != 3'h0)
      |-> dark_cnt <= 11'(led_regs_pkg::DELAY_MAX_CYCLES + 8))
    else $error("Colour lit after the longest settling delay");
  a_ack_scl_low:
    assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
      $changed(o_sda_oe) |-> !i_scl)
    else $error("Data line moved while SCL was high");
  a_sda_low_only:
    assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
      o_sda_oe |-> o_sda_out == 1'b0)
    else $error("Data line driven high");

  c_fault: cover property (@(posedge i_clock) $rose(o_fault));
  c_fault_clear: cover property (@(posedge i_clock) $fell(o_fault));
  c_lit: cover property (@(posedge i_clock) $rose(|o_led_on));
  c_ack: cover property (@(posedge i_link_clock) $rose(o_sda_oe));
endmodule

bind led_fault_and_delay_regs led_fault_and_delay_regs_asserts
  i_led_fault_and_delay_regs_asserts (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_link_clock(i_link_clock),
  .i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .i_led_open(i_led_open), .i_led_short(i_led_short),
  .i_colour_request(i_colour_request), .o_led_on(o_led_on),
  .o_fault(o_fault)
);

/* bench/led_host_model.sv */
// Serial bus master of the host controller, timed on core clocks.
// Assumes a pull-up on SDA, so a released line reads high.
`timescale 1ns/10ps
module led_host_model #(
  parameter int LOW_HALF = 17,
  parameter int HIGH     = 16
) (
  // Clock
  input  wire logic i_clock,
  // Serial pins
  input  wire logic i_sda,
  output logic      o_scl = 1'b1,
  output logic      o_sda = 1'b1
);
  task automatic pins(input logic scl, input logic sda, input int n);
    o_scl <= scl;
    o_sda <= sda;
    repeat (n) @(posedge i_clock);
  endtask

  // Also serves as repeated start from a low SCL
  task automatic bus_start();
    @(posedge i_clock);
    pins(o_scl, 1'b1, LOW_HALF);
    pins(1'b1, 1'b1, HIGH);
    pins(1'b1, 1'b0, HIGH);
    pins(1'b0, 1'b0, LOW_HALF);
  endtask

  task automatic bus_stop();
    pins(1'b0, 1'b0, LOW_HALF);
    pins(1'b1, 1'b0, HIGH);
    pins(1'b1, 1'b1, 2 * LOW_HALF);
  endtask

  // Data moves only while SCL is low; sampled late in the high phase
  task automatic xfer_bit(input logic b, output logic r);
    pins(1'b0, b, LOW_HALF);
    pins(1'b1, b, HIGH);
    r = i_sda;
    pins(1'b0, b, LOW_HALF);
  endtask

  task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] r, output logic acked);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r[i]);
    end
    xfer_bit(ack_in, a);
    acked = ~a;
  endtask

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] idx,
                           input logic [7:0] data, output logic ok);
    logic [7:0] r;
    logic [2:0] a;
    bus_start();
    xfer_byte({addr, 1'b0}, 1'b1, r, a[0]);
    xfer_byte(idx, 1'b1, r, a[1]);
    xfer_byte(data, 1'b1, r, a[2]);
    bus_stop();
    ok = &a;
  endtask

  task automatic read_reg(input logic [7:0] idx, output logic [7:0] data,
                          output logic ok);
    logic [7:0] r;
    logic [2:0] a;
    logic       last;
    bus_start();
    xfer_byte({led_regs_pkg::DEVICE_ADDRESS, 1'b0}, 1'b1, r, a[0]);
    xfer_byte(idx, 1'b1, r, a[1]);
    bus_start();
    xfer_byte({led_regs_pkg::DEVICE_ADDRESS, 1'b1}, 1'b1, r, a[2]);
    // No acknowledge on the data byte ends the read
    xfer_byte(8'hFF, 1'b1, data, last);
    bus_stop();
    ok = &a;
  endtask
endmodule

/* bench/led_fault_and_delay_regs_tb.sv */
// Self-checking bench for the LED fault and delay register bank.
// Assumes the host model times every serial transfer.
`timescale 1ns/10ps
module led_fault_and_delay_regs_tb;
  logic       i_clock          = 1'b0;
  logic       i_rst_n          = 1'b0;
  logic       i_link_clock     = 1'b0;
  logic [2:0] i_led_open       = 3'h0;
  logic [2:0] i_led_short      = 3'h0;
  logic [2:0] i_colour_request = 3'h0;
  logic       host_scl;
  logic       host_sda;
  logic       sda_wire;
  logic       o_sda_out;
  logic       o_sda_oe;
  logic [2:0] o_led_on;
  logic       o_fault;
  logic       ok;
  logic [7:0] rdata;
  int         n_mismatch       = 0;
  int         tests_run        = 0;
  // Red, green, blue open, then the same three shorts
  logic [7:0] fault_bit [6] = '{8'h02, 8'h80, 8'h10, 8'h01, 8'h40, 8'h08};

  always #20 i_clock = ~i_clock;
  // Phase unrelated to the core clock
  initial #3.3 forever #6 i_link_clock = ~i_link_clock;
  assign sda_wire = host_sda & ~(o_sda_oe & ~o_sda_out);

  led_fault_and_delay_regs i_led_fault_and_delay_regs (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_link_clock(i_link_clock),
    .i_scl(host_scl), .i_sda(sda_wire), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .i_led_open(i_led_open),
    .i_led_short(i_led_short), .i_colour_request(i_colour_request),
    .o_led_on(o_led_on), .o_fault(o_fault)
  );
  led_host_model i_led_host_model (
    .i_clock(i_clock), .i_sda(sda_wire), .o_scl(host_scl),
    .o_sda(host_sda)
  );

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [10:0] seen,
                       input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    i_led_host_model.write_reg(led_regs_pkg::DEVICE_ADDRESS, idx, data,
                               ok);
    check("write ack", 11'(ok), 11'h001);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    i_led_host_model.read_reg(idx, rdata, ok);
    check("read ack", 11'(ok), 11'h001);
    check($sformatf("register %0h", idx), 11'(rdata), 11'(exp));
  endtask

  task automatic chk_fault(input logic exp);
    repeat (10) @(posedge i_clock);
    @(negedge i_clock);
    check("fault pin", 11'(o_fault), 11'(exp));
    @(posedge i_clock);
  endtask

  // Go dark, then time the lighting of colour c against its code
  task automatic light(input int c, input int code);
    int n;
    int exp;
    exp = led_regs_pkg::DELAY_BASE_CYCLES
        + code * led_regs_pkg::DELAY_STEP_CYCLES;
    n = 0;
    i_colour_request <= 3'h0;
    repeat (10) @(posedge i_clock);
    i_colour_request <= 3'(1 << c);
    while (o_led_on !== 3'(1 << c) && n < 2000) begin
      @(negedge i_clock);
      n++;
    end
    check("settle window", 11'(n >= exp && n <= exp + 8), 11'h001);
    if (n >= 2000) begin
      end_sim();
    end else begin
      @(posedge i_clock);
    end
  endtask

  initial begin
    repeat (20) @(posedge i_clock);
    @(negedge i_clock);
    check("reset outputs", {8'h00, o_fault, o_sda_oe, |o_led_on}, 11'h0);
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (10) @(posedge i_clock);
    rd_chk(8'h05, 8'h01);
    rd_chk(8'h06, 8'hFF);
    rd_chk(8'h07, 8'h00);
    wr(8'h05, 8'hFE);
    rd_chk(8'h05, 8'h00);
    wr(8'h05, 8'hFF);
    rd_chk(8'h05, 8'h01);
    wr(8'h06, 8'h00);
    rd_chk(8'h06, 8'h24);
    light(0, 0);
    light(2, 0);
    wr(8'h06, 8'hEE);
    rd_chk(8'h06, 8'hEE);
    light(0, 3);
    light(1, 2);
    light(2, 1);
    i_colour_request <= 3'h0;
    i_led_host_model.write_reg(7'h29, 8'h06, 8'h00, ok);
    check("foreign ack", 11'(ok), 11'h000);
    rd_chk(8'h06, 8'hEE);
    wr(8'h04, 8'h55);
    rd_chk(8'h04, 8'h00);
    for (int k = 0; k < 6; k++) begin
      i_led_open <= (k < 3) ? 3'(1 << k) : 3'h0;
      i_led_short <= (k < 3) ? 3'h0 : 3'(1 << (k - 3));
      chk_fault(1'b1);
      i_led_open <= 3'h0;
      i_led_short <= 3'h0;
      chk_fault(1'b1);
      rd_chk(8'h07, fault_bit[k]);
      wr(8'h05, 8'h00);
      chk_fault(1'b0);
      wr(8'h05, 8'h01);
      rd_chk(8'h07, 8'h00);
    end
    i_led_open <= 3'h7;
    i_led_short <= 3'h7;
    chk_fault(1'b1);
    i_led_open <= 3'h0;
    i_led_short <= 3'h0;
    wr(8'h07, 8'h00);
    rd_chk(8'h07, 8'hDB);
    wr(8'h05, 8'h00);
    i_led_open <= 3'h1;
    chk_fault(1'b0);
    i_led_open <= 3'h0;
    repeat (5) @(posedge i_clock);
    wr(8'h05, 8'h01);
    rd_chk(8'h07, 8'h00);
    end_sim();
  end
endmodule
